// ==== irq_out_defines.svh ====
`ifndef IRQ_OUT_DEFINES_SVH
`define IRQ_OUT_DEFINES_SVH

// ----------------------------------------------------------------
// Command indexes
// ----------------------------------------------------------------
`define CMD_HWCFG_RD 8'h20
`define CMD_HWCFG_WR 8'ha0
`define CMD_L2_STAT_RD 8'h03
`define CMD_L2_STAT_WR 8'h83
`define CMD_L2_EN_RD 8'h04
`define CMD_L2_EN_WR 8'h84
`define CMD_L1_STAT_RD 8'h24
`define CMD_L1_STAT_WR 8'ha4
`define CMD_L1_EN_RD 8'h25
`define CMD_L1_EN_WR 8'ha5
`define CMD_SOFT_RESET 8'ha9

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define HWCFG_PIN_EN_BIT 0
`define HWCFG_TRIG_BIT 1
`define HWCFG_POL_BIT 2
`define L2_MIE_BIT 31
`define L2_HI_WORD_BASE 16
`define L1_HC_EVENT_BIT 5
`define HWCFG_RESET 16'h0000
`define WORD_ZERO 16'h0000
`define EV_ZERO 6'h00

`endif

// ==== irq_out_pkg.sv ====
package irq_out_pkg;
    // Decoded pin configuration carried as one bundle
    typedef struct packed {
        logic pin_latch_enable;
        logic trigger_edge;
        logic polarity_high;
    } pin_cfg_s;

    // Host port access phase
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_LOW = 3'b010,
        PH_HIGH = 3'b100
    } phase_e;
endpackage

// ==== irq_pin_driver.sv ====
`timescale 1ns/1ps
`include "irq_out_defines.svh"

module irq_pin_driver (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic aggregate_i,
    input wire irq_out_pkg::pin_cfg_s cfg_i,
    output logic irq_pin_o
);
    // ----------------------------------------------------------------
    // Latch and pin shaping
    // ----------------------------------------------------------------
    logic latch_reg;
    logic latch_next;
    logic latch_d_reg;
    logic pulse_reg;
    logic active_w;
    logic pin_next;

    // Latch follows the aggregate only while the pin enable is set
    assign latch_next = cfg_i.pin_latch_enable ? aggregate_i : latch_reg;
    // Edge modes fire one clock on a rising latched value
    assign active_w = cfg_i.trigger_edge ? pulse_reg : latch_reg;
    assign pin_next = cfg_i.polarity_high ? active_w : ~active_w;

    // Registered so the pin never glitches on a decode change
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            latch_reg <= 1'b0;
            latch_d_reg <= 1'b0;
            pulse_reg <= 1'b0;
            irq_pin_o <= 1'b1;
        end else begin
            latch_reg <= latch_next;
            latch_d_reg <= latch_reg;
            pulse_reg <= latch_reg & ~latch_d_reg;
            irq_pin_o <= pin_next;
        end
    end

    a_latch_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !cfg_i.pin_latch_enable |=> latch_reg == $past(latch_reg))
        else $error("latch moved while pin enable low");
    a_latch_sample: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cfg_i.pin_latch_enable |=> latch_reg == $past(aggregate_i))
        else $error("latch missed aggregate sample");
    a_edge_pulse: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(latch_reg) |=> pulse_reg ##1 !pulse_reg)
        else $error("edge pulse not one clock");
    c_edge_pulse: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cfg_i.trigger_edge && pulse_reg);
endmodule

// ==== irq_receiver.sv ====
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Processor interrupt input model
// ----------------------------------------------------------------
module irq_receiver (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic irq_pin_i,
    input wire logic pol_i,
    input wire logic armed_i,
    output logic [7:0] pulse_cnt_o
);
    logic seen_reg;
    // Asserted level follows the configured polarity
    wire active = pol_i ? irq_pin_i : ~irq_pin_i;

    // Count each new assertion; disarmed while the mode changes to avoid false counts
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            seen_reg <= 1'b0;
            pulse_cnt_o <= 8'h00;
        end else begin
            seen_reg <= active;
            if (armed_i && active && !seen_reg) begin
                pulse_cnt_o <= pulse_cnt_o + 8'h01;
            end
        end
    end
endmodule

// ==== usb_host_interrupt_output.sv ====
// Contract
// - Pin has four modes: level low, level high, edge low, edge high.
// - Trigger and polarity selects sit in config bits 1 and 2, index 20H/A0H.
// - Config bit 0 enables updating of the interrupt pin.
// - Six second-level flags, each set when its controller event happens.
// - OR of status AND enable, gated by master enable bit 31.
// - Gated second-level result sets the controller event bit in first level.
// - Six first-level flags, each counts only when its enable bit is set.
// - Latch held by pin enable; pin holds while enable is zero.
// - Command index then 16-bit data words, low word first for 32-bit.
`timescale 1ns/1ps
`include "irq_out_defines.svh"

module usb_host_interrupt_output #(
    parameter int NUM_EVENTS = 6
) (
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic cs_n_i,
    input wire logic a0_i,
    input wire logic rd_n_i,
    input wire logic wr_n_i,
    input wire logic [15:0] data_i,
    input wire logic [NUM_EVENTS-1:0] l2_event_i,
    input wire logic [NUM_EVENTS-2:0] l1_event_i,
    output logic [15:0] data_o,
    output logic data_oe_n_o,
    output logic irq_pin_o
);
    // ----------------------------------------------------------------
    // Host port strobes
    // ----------------------------------------------------------------
    logic rd_d_reg;
    logic wr_d_reg;
    logic [7:0] cmd_reg;
    irq_out_pkg::phase_e phase_reg;
    irq_out_pkg::phase_e phase_next;
    logic [15:0] low_hold_reg;

    // Write strobes act on their falling edge and reads on their release, so one access counts once
    wire rd_act = !cs_n_i && !rd_n_i;
    wire wr_act = !cs_n_i && !wr_n_i;
    wire cmd_wr = wr_act && !wr_d_reg && a0_i;
    wire dat_wr = wr_act && !wr_d_reg && !a0_i;
    wire dat_rd_end = !rd_act && rd_d_reg;
    wire is_hi = (phase_reg == irq_out_pkg::PH_HIGH);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [15:0] hwcfg_reg;
    logic [NUM_EVENTS-1:0] l2_stat_reg;
    logic [NUM_EVENTS-1:0] l2_en_reg;
    logic l2_mie_reg;
    logic [NUM_EVENTS-1:0] l1_stat_reg;
    logic [NUM_EVENTS-1:0] l1_en_reg;

    function automatic logic is_cmd(input logic [7:0] c, input logic [7:0] k);
        is_cmd = (c == k);
    endfunction

    // Write decode for each register
    wire wr_hwcfg = dat_wr && is_cmd(cmd_reg, `CMD_HWCFG_WR);
    wire wr_l2_stat = dat_wr && is_cmd(cmd_reg, `CMD_L2_STAT_WR);
    wire wr_l2_en_lo = dat_wr && is_cmd(cmd_reg, `CMD_L2_EN_WR) && !is_hi;
    wire wr_l2_en_hi = dat_wr && is_cmd(cmd_reg, `CMD_L2_EN_WR) && is_hi;
    wire wr_l1_stat = dat_wr && is_cmd(cmd_reg, `CMD_L1_STAT_WR);
    wire wr_l1_en = dat_wr && is_cmd(cmd_reg, `CMD_L1_EN_WR);
    wire soft_rst = cmd_wr && is_cmd(data_i[7:0], `CMD_SOFT_RESET);
    wire is_32 = is_cmd(cmd_reg, `CMD_L2_EN_WR) || is_cmd(cmd_reg, `CMD_L2_EN_RD);

    // Phase advances per data access; 32-bit registers take two words
    always_comb begin
        phase_next = phase_reg;
        if (cmd_wr) begin
            phase_next = irq_out_pkg::PH_LOW;
        end else if (dat_wr || dat_rd_end) begin
            case (phase_reg)
                irq_out_pkg::PH_LOW: phase_next = is_32 ? irq_out_pkg::PH_HIGH
                                                        : irq_out_pkg::PH_IDLE;
                irq_out_pkg::PH_HIGH: phase_next = irq_out_pkg::PH_IDLE;
                default: phase_next = irq_out_pkg::PH_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Event aggregation
    // ----------------------------------------------------------------
    wire l2_summary = |(l2_stat_reg & l2_en_reg) & l2_mie_reg;
    wire [NUM_EVENTS-1:0] l1_src = {l2_summary, l1_event_i};
    wire l1_aggregate = |(l1_stat_reg & l1_en_reg);

    // Status flags: hardware set wins over a software clear (write one at second level, write zero at first)
    logic [NUM_EVENTS-1:0] l2_stat_next;
    logic [NUM_EVENTS-1:0] l1_stat_next;
    genvar g;
    generate
        for (g = 0; g < NUM_EVENTS; g++) begin : g_flag
            assign l2_stat_next[g] = l2_event_i[g] ||
                (l2_stat_reg[g] && !(wr_l2_stat && data_i[g]));
            // Writing one to a first-level bit also sets it, so software can
            // re-arm all bits before re-enabling the pin
            assign l1_stat_next[g] = l1_src[g] ||
                (wr_l1_stat ? data_i[g] : l1_stat_reg[g]);
        end
    endgenerate

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_d_reg <= 1'b0;
            wr_d_reg <= 1'b0;
            cmd_reg <= 8'h00;
            phase_reg <= irq_out_pkg::PH_IDLE;
            low_hold_reg <= `WORD_ZERO;
        end else begin
            rd_d_reg <= rd_act;
            wr_d_reg <= wr_act;
            phase_reg <= phase_next;
            if (cmd_wr) begin
                cmd_reg <= data_i[7:0];
            end
            if (wr_l2_en_lo) begin
                low_hold_reg <= data_i;
            end
        end
    end

    // Register file; soft reset returns every register to its reset value
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hwcfg_reg <= `HWCFG_RESET;
            l2_stat_reg <= `EV_ZERO;
            l2_en_reg <= `EV_ZERO;
            l2_mie_reg <= 1'b0;
            l1_stat_reg <= `EV_ZERO;
            l1_en_reg <= `EV_ZERO;
        end else if (soft_rst) begin
            hwcfg_reg <= `HWCFG_RESET;
            l2_stat_reg <= `EV_ZERO;
            l2_en_reg <= `EV_ZERO;
            l2_mie_reg <= 1'b0;
            l1_stat_reg <= `EV_ZERO;
            l1_en_reg <= `EV_ZERO;
        end else begin
            l2_stat_reg <= l2_stat_next;
            l1_stat_reg <= l1_stat_next;
            if (wr_hwcfg) begin
                hwcfg_reg <= data_i;
            end
            // Enable takes effect only once the upper word completes it
            if (wr_l2_en_hi) begin
                l2_en_reg <= low_hold_reg[NUM_EVENTS-1:0];
                l2_mie_reg <= data_i[`L2_MIE_BIT-`L2_HI_WORD_BASE];
            end
            if (wr_l1_en) begin
                l1_en_reg <= data_i[NUM_EVENTS-1:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [15:0] rd_word;
    always_comb begin
        rd_word = `WORD_ZERO;
        if (is_cmd(cmd_reg, `CMD_HWCFG_RD)) begin
            rd_word = hwcfg_reg;
        end else if (is_cmd(cmd_reg, `CMD_L2_STAT_RD)) begin
            rd_word = {10'h000, l2_stat_reg};
        end else if (is_cmd(cmd_reg, `CMD_L2_EN_RD)) begin
            rd_word = is_hi ? {l2_mie_reg, 15'h0000} : {10'h000, l2_en_reg};
        end else if (is_cmd(cmd_reg, `CMD_L1_STAT_RD)) begin
            rd_word = {10'h000, l1_stat_reg};
        end else if (is_cmd(cmd_reg, `CMD_L1_EN_RD)) begin
            rd_word = {10'h000, l1_en_reg};
        end
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_o <= `WORD_ZERO;
            data_oe_n_o <= 1'b1;
        end else begin
            data_o <= rd_word;
            data_oe_n_o <= !(rd_act && !a0_i);
        end
    end

    // ----------------------------------------------------------------
    // Pin stage
    // ----------------------------------------------------------------
    irq_out_pkg::pin_cfg_s pin_cfg;
    assign pin_cfg.pin_latch_enable = hwcfg_reg[`HWCFG_PIN_EN_BIT];
    assign pin_cfg.trigger_edge = hwcfg_reg[`HWCFG_TRIG_BIT];
    assign pin_cfg.polarity_high = hwcfg_reg[`HWCFG_POL_BIT];

    irq_pin_driver u_pin (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .aggregate_i(l1_aggregate),
        .cfg_i(pin_cfg),
        .irq_pin_o(irq_pin_o)
    );

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_l2_set: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        l2_event_i[0] && !soft_rst |=> l2_stat_reg[0])
        else $error("second-level flag not set");
    a_l2_gate: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !l2_mie_reg |-> !l2_summary)
        else $error("summary without master enable");
    a_l1_chain: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        l2_summary && !soft_rst |=> l1_stat_reg[`L1_HC_EVENT_BIT])
        else $error("first-level event bit not set");
    a_l1_mask: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        l1_en_reg == `EV_ZERO |-> !l1_aggregate)
        else $error("aggregate with all enables off");
    a_pin_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !pin_cfg.pin_latch_enable && $stable(hwcfg_reg) ##1
        !pin_cfg.pin_latch_enable && $stable(hwcfg_reg)
        |=> $stable(irq_pin_o))
        else $error("pin moved while pin enable low");
    a_level_mode: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        pin_cfg.pin_latch_enable && !pin_cfg.trigger_edge && $stable(hwcfg_reg)
        ##1 $stable(hwcfg_reg) ##1 $stable(hwcfg_reg)
        |-> irq_pin_o == (pin_cfg.polarity_high ~^ $past(l1_aggregate, 2)))
        else $error("level mode pin wrong");
    a_cmd_phase: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        cmd_wr |=> phase_reg == irq_out_pkg::PH_LOW)
        else $error("command did not open data phase");
    a_cfg_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_hwcfg && !soft_rst |=> hwcfg_reg == $past(data_i))
        else $error("configuration write lost");

    c_level_low: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        pin_cfg.pin_latch_enable && !pin_cfg.polarity_high && !irq_pin_o);
    c_level_high: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        pin_cfg.pin_latch_enable && pin_cfg.polarity_high && irq_pin_o);
    c_l2_path: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        l2_summary ##1 l1_aggregate);
    c_en_32bit: cover property (@(posedge ref_clk_i) disable iff (!rstn_i)
        wr_l2_en_hi);
endmodule

// ==== usb_host_interrupt_output_bench.sv ====
`timescale 1ns/1ps
module usb_host_interrupt_output_bench;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic cs_n = 1'b1, a0 = 1'b0, rd_n = 1'b1, wr_n = 1'b1;
    logic [15:0] din = 16'h0000;
    logic [5:0] l2_ev = 6'h00;
    logic [4:0] l1_ev = 5'h00;
    logic [15:0] data_o;
    logic data_oe_n, irq_pin, pol = 1'b0, armed = 1'b0;
    logic [7:0] pulses, exp_pulses = 8'h00;
    logic [15:0] rd_q[$];
    logic [8:0] pin_q[$];
    logic pin_look = 1'b0, taken = 1'b0;
    logic [15:0] cfg;
    int err_total = 0, samples_checked = 0, seed = 32'h4e8eaa97, k, j, m;

    always #50 ref_clk_i = ~ref_clk_i;

    usb_host_interrupt_output dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n),
        .a0_i(a0), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(din), .l2_event_i(l2_ev),
        .l1_event_i(l1_ev), .data_o(data_o), .data_oe_n_o(data_oe_n), .irq_pin_o(irq_pin));
    irq_receiver cpu (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .irq_pin_i(irq_pin),
        .pol_i(pol), .armed_i(armed), .pulse_cnt_o(pulses));

    // ----------------------------------------------------------------
    // Compare and bus tasks
    // ----------------------------------------------------------------
    task cmp_word(input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH read data expected %h seen %h", e, g);
        end
    endtask
    task cmp_pin(input logic [8:0] e, input logic [8:0] g);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH pulses/pin expected %h seen %h", e, g);
        end
    endtask
    // Strobe low one cycle, then two high cycles before the next access
    task bus_wr(input logic a, input logic [15:0] d);
        @(negedge ref_clk_i);
        cs_n = 1'b0; a0 = a; wr_n = 1'b0; din = d;
        @(negedge ref_clk_i);
        cs_n = 1'b1; wr_n = 1'b1;
        @(negedge ref_clk_i);
    endtask
    task reg_wr(input logic [7:0] c, input logic [15:0] d);
        bus_wr(1'b1, {8'h00, c});
        bus_wr(1'b0, d);
    endtask
    // One data-port read; a second call reads the upper word of a 32-bit register
    task rd_data(input logic [15:0] e);
        rd_q.push_back(e);
        @(negedge ref_clk_i);
        cs_n = 1'b0; a0 = 1'b0; rd_n = 1'b0;
        repeat (2) @(negedge ref_clk_i);
        cs_n = 1'b1; rd_n = 1'b1;
        @(negedge ref_clk_i);
    endtask
    task reg_rd(input logic [7:0] c, input logic [15:0] e);
        bus_wr(1'b1, {8'h00, c});
        rd_data(e);
    endtask
    task pin_chk(input logic v);
        pin_q.push_back({exp_pulses, v});
        pin_look <= 1'b1;
        repeat (2) @(negedge ref_clk_i);
    endtask
    task fire(input logic lvl2, input int b);
        @(negedge ref_clk_i);
        if (lvl2) l2_ev = 6'h01 << b; else l1_ev = 5'h01 << b;
        @(negedge ref_clk_i);
        l2_ev = 6'h00; l1_ev = 5'h00;
        repeat (8) @(negedge ref_clk_i);
    endtask
    // Mode bit0 is polarity, bit1 is edge; pin enable always set here
    task set_mode(input int md);
        pol = md[0];
        cfg = {13'h0000, md[0], md[1], 1'b1};
        armed = 1'b0;
        reg_wr(8'ha0, cfg);
        repeat (4) @(negedge ref_clk_i);
        armed = 1'b1;
    endtask
    task tally_and_finish;
        // Notes never taken mean a result never showed on the pins
        if (rd_q.size() != 0 || pin_q.size() != 0) begin
            err_total++;
            $display("MISMATCH pending notes expected 0 seen %0d", rd_q.size() + pin_q.size());
        end
        $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Monitor: oldest note is compared when a result shows
    // ----------------------------------------------------------------
    always @(negedge ref_clk_i) begin
        if (data_oe_n === 1'b0 && !taken && rd_q.size() > 0) begin
            cmp_word(rd_q.pop_front(), data_o);
            taken = 1'b1;
        end else if (data_oe_n === 1'b1) begin
            taken = 1'b0;
        end
        if (pin_look && pin_q.size() > 0) begin
            cmp_pin(pin_q.pop_front(), {pulses, irq_pin});
            pin_look <= 1'b0;
        end
    end

    // Generous bound: whole sequence needs well under 2000 cycles
    initial begin
        #(100 * 20000);
        err_total++;
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        pin_chk(1'b1);
        reg_rd(8'h20, 16'h0000);
        reg_rd(8'h3f, 16'h0000);
        reg_wr(8'ha5, 16'h0020);
        for (m = 0; m < 4; m++) begin
            k = $unsigned($random(seed)) % 6;
            set_mode(m);
            reg_rd(8'h20, cfg);
            bus_wr(1'b1, 16'h0084);
            bus_wr(1'b0, 16'h0001 << k);
            bus_wr(1'b0, 16'h8000);
            reg_rd(8'h04, 16'h0001 << k);
            rd_data(16'h8000);
            fire(1'b1, k);
            exp_pulses++;
            pin_chk(m[1] ? ~pol : pol);
            reg_rd(8'h03, 16'h0001 << k);
            reg_rd(8'h24, 16'h0020);
            reg_wr(8'h83, 16'h003f);
            reg_wr(8'ha4, 16'h0000);
            pin_chk(~pol);
        end
        // Master enable off: status sets but nothing reaches first level
        set_mode(1);
        armed = 1'b0;
        k = $unsigned($random(seed)) % 6;
        bus_wr(1'b1, 16'h0084);
        bus_wr(1'b0, 16'h003f);
        bus_wr(1'b0, 16'h0000);
        reg_rd(8'h04, 16'h003f);
        rd_data(16'h0000);
        fire(1'b1, k);
        reg_rd(8'h03, 16'h0001 << k);
        reg_rd(8'h24, 16'h0000);
        pin_chk(1'b0);
        reg_wr(8'h83, 16'h003f);
        // First-level enable gating
        j = $unsigned($random(seed)) % 5;
        reg_wr(8'ha5, 16'h0000);
        fire(1'b0, j);
        pin_chk(1'b0);
        reg_rd(8'h24, 16'h0001 << j);
        reg_wr(8'ha5, 16'h0001 << j);
        repeat (4) @(negedge ref_clk_i);
        pin_chk(1'b1);
        // Disable by clearing status, events while held
        reg_rd(8'h20, 16'h0005);
        reg_wr(8'ha4, 16'h0000);
        reg_wr(8'ha0, 16'h0004);
        fire(1'b0, j);
        pin_chk(1'b0);
        reg_rd(8'h24, 16'h0001 << j);
        reg_wr(8'ha4, 16'h003f);
        pin_chk(1'b0);
        reg_wr(8'ha0, 16'h0005);
        repeat (4) @(negedge ref_clk_i);
        pin_chk(1'b1);
        // Mask by clearing enables, then restore
        reg_wr(8'ha5, 16'h0000);
        reg_wr(8'ha0, 16'h0004);
        fire(1'b0, j);
        pin_chk(1'b0);
        reg_wr(8'ha5, 16'h0001 << j);
        reg_wr(8'ha0, 16'h0005);
        repeat (4) @(negedge ref_clk_i);
        pin_chk(1'b1);
        // Asserted pin held while status is wiped
        reg_wr(8'ha0, 16'h0004);
        reg_wr(8'ha4, 16'h0000);
        repeat (4) @(negedge ref_clk_i);
        pin_chk(1'b1);
        // Soft reset command clears the registers
        bus_wr(1'b1, 16'h00a9);
        reg_rd(8'h20, 16'h0000);
        reg_rd(8'h25, 16'h0000);
        tally_and_finish();
    end
endmodule
